// >>> core/lcdm_pkg.sv
// Constants, types and helpers for the LCD multiplex drive timing block
package lcdm_pkg;
    // Drive configurations
    typedef enum logic [1:0] {
        MODE_STATIC = 2'h0,
        MODE_MUX2 = 2'h1,
        MODE_MUX3 = 2'h2,
        MODE_MUX4 = 2'h3
    } lcdm_mode_t;
    // Sizes
    localparam int SEG_N = 60;
    localparam int BP_N = 4;
    // Frame divider: working clock ticks per frame, per half frame
    localparam logic [4:0] FRAME_DIV = 5'h18;
    localparam logic [4:0] HALF_LEN = 5'h0C;
    // Working clock ticks per multiplex slot inside a half frame
    localparam logic [4:0] SLOT_MUX2 = 5'h06;
    localparam logic [4:0] SLOT_MUX3 = 5'h04;
    localparam logic [4:0] SLOT_MUX4 = 5'h03;
    // Working clock rate and system clock rate
    localparam int OSC_FREQ_HZ = 1536;
    localparam int CLK_FREQ_HZ = 50000000;
    localparam int OSC_HALF_CYC = CLK_FREQ_HZ / (2 * OSC_FREQ_HZ);
    // Bias denominators, 1 + a
    localparam logic [1:0] DEN_STATIC = 2'h1;
    localparam logic [1:0] DEN_HALF = 2'h2;
    localparam logic [1:0] DEN_THIRD = 2'h3;
    // Power-on drive configuration
    localparam lcdm_mode_t RST_MODE = MODE_MUX4;
    localparam logic RST_HALF_BIAS = 1'b0;
    localparam logic RST_DISPLAY_ON = 1'b0;
    // Programmed drive configuration
    typedef struct packed {
        lcdm_mode_t mode;
        logic halfBias;
        logic displayOn;
    } lcdm_cfg_t;
    // Panel drive: level k means k / biasDenom of the panel supply level
    typedef struct packed {
        logic [1:0] biasDenom;
        logic [BP_N-1:0][1:0] backplane_outputs;
        logic [SEG_N-1:0][1:0] segment_outputs;
    } lcdm_drive_t;
    // Multiplex slot from position inside a half frame
    function automatic logic [1:0] slotOf(input logic [4:0] pos, input lcdm_mode_t m);
        unique case (m)
            MODE_STATIC: slotOf = 2'h0;
            MODE_MUX2: slotOf = 2'(pos / SLOT_MUX2);
            MODE_MUX3: slotOf = 2'(pos / SLOT_MUX3);
            MODE_MUX4: slotOf = 2'(pos / SLOT_MUX4);
        endcase
    endfunction
    // Memory row that drives a backplane, duplicating in the lower modes
    function automatic logic [1:0] rowOf(input logic [1:0] bp, input lcdm_mode_t m);
        unique case (m)
            MODE_STATIC: rowOf = 2'h0;
            MODE_MUX2: rowOf = {1'b0, bp[0]};
            MODE_MUX3: rowOf = (bp == 2'h3) ? 2'h1 : bp;
            MODE_MUX4: rowOf = bp;
        endcase
    endfunction
endpackage

// >>> core/lcdm_drive_timing.sv
// Clock selection, frame timing and drive level selection for a segment LCD
//
// Overview of operation
// - Outputs follow last programmed drive configuration
// - Static, 1:2, 1:3, 1:4 configurations supported
// - Two backplanes allow half or third bias
// - Half bias allowed with three, four backplanes
// - Bias fraction is one over one plus a
// - One working clock times all drive logic
// - Select strap low uses internal oscillator
// - Internal oscillator driven out on clock pin
// - Select strap high takes clock pin input
// - Cascade frames aligned through active-low sync
// - Frame rate is working clock over 24
// - Timing moves display memory to output stage
// - Holding register stable while waveforms generated
// - Sixty segment outputs, numbered 0 to 59
// - Segment level from slot and held bit
// - Reset: 1:4, third bias, display off
// - Rows multiplex onto backplanes, columns onto segments
// - Backplanes duplicated in lower multiplex modes
`timescale 1ns/1ps
module lcdm_drive_timing #(
    // System cycles per half period of the internal oscillator
    parameter int oscHalfCycles = lcdm_pkg::OSC_HALF_CYC
) (
    // Clock, reset, enable
    input wire logic clock,
    input wire logic nrst,
    input wire logic clkEn,
    // Oscillator select strap, low picks the internal oscillator
    input wire logic intOscSel,
    // Two-way working clock pin
    input wire logic clkPinIn,
    output logic clkPinOut,
    output logic clkPinOe,
    // Open-drain cascade sync pin, active low
    input wire logic syncPinIn_n,
    output logic syncPinOut_n,
    output logic syncPinOe,
    // Drive configuration from the command decoder
    input wire logic cfgWrite,
    input wire lcdm_pkg::lcdm_cfg_t cfgIn,
    // Display memory contents, column by row
    input wire logic [lcdm_pkg::SEG_N-1:0][3:0] ramData,
    // Panel drive levels
    output lcdm_pkg::lcdm_drive_t drive_r,
    // Frame start, one system cycle
    output logic frameStart
);
    import lcdm_pkg::*;

    // Strap state, safe default is not driving the clock pin
    logic strap_r;
    logic strapTaken_r;
    // Internal oscillator
    logic [15:0] oscCnt_r;
    logic oscLevel_r;
    logic oscTick;
    // External clock edge detect
    logic extPrev_r;
    logic extTick;
    // Working clock tick
    logic tick;
    // Frame divider
    logic [4:0] frameCnt_r;
    logic [4:0] frameCnt_nxt;
    logic syncRestart;
    // Configuration: programmed and in use
    lcdm_cfg_t cfg_r;
    lcdm_cfg_t act_r;
    // Display holding register
    logic [SEG_N-1:0][3:0] hold_r;
    // Combinational drive image
    lcdm_drive_t drive_nxt;

    // Catch the strap once after reset release
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            strap_r <= 1'b1;
            strapTaken_r <= 1'b0;
        end else if (clkEn && !strapTaken_r) begin
            strap_r <= intOscSel;
            strapTaken_r <= 1'b1;
        end
    end

    // Internal oscillator, divided from the system clock
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            oscCnt_r <= 16'h0000;
            oscLevel_r <= 1'b0;
        end else if (clkEn) begin
            if (oscCnt_r == 16'(oscHalfCycles - 1)) begin
                oscCnt_r <= 16'h0000;
                oscLevel_r <= !oscLevel_r;
            end else begin
                oscCnt_r <= oscCnt_r + 16'h0001;
            end
        end
    end

    // Rising edge of the internal oscillator
    assign oscTick = (oscCnt_r == 16'(oscHalfCycles - 1)) && !oscLevel_r;

    // Pin input is synchronous, so one register suffices for the edge
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            extPrev_r <= 1'b0;
        end else if (clkEn) begin
            extPrev_r <= clkPinIn;
        end
    end
    assign extTick = clkPinIn && !extPrev_r;

    // Single working clock from the selected source
    assign tick = clkEn && strapTaken_r && (strap_r ? extTick : oscTick);

    // Clock pin drives only in internal mode
    assign clkPinOut = oscLevel_r;
    assign clkPinOe = strapTaken_r && !strap_r;

    // Sync pin pulled low through the first tick of every frame except one begun by a sync restart
    assign syncPinOut_n = 1'b0;
    assign syncPinOe = (frameCnt_r == 5'h00);

    // Another device holds sync low while we are mid-frame
    assign syncRestart = !syncPinIn_n && !syncPinOe;

    // Next divider value
    always_comb begin
        frameCnt_nxt = frameCnt_r;
        if (syncRestart) begin
            // Fall in behind the device that started its frame
            frameCnt_nxt = 5'h01;
        end else if (frameCnt_r == FRAME_DIV - 5'h01) begin
            frameCnt_nxt = 5'h00;
        end else begin
            frameCnt_nxt = frameCnt_r + 5'h01;
        end
    end

    // Free-running frame divider on the working clock
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            frameCnt_r <= 5'h00;
        end else if (tick) begin
            frameCnt_r <= frameCnt_nxt;
        end
    end

    // A new frame begins on wrap or restart
    assign frameStart = tick && ((frameCnt_r == FRAME_DIV - 5'h01) || syncRestart);

    // Programmed configuration, latched from the command decoder
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            cfg_r <= '{RST_MODE, RST_HALF_BIAS, RST_DISPLAY_ON};
        end else if (clkEn && cfgWrite) begin
            cfg_r <= cfgIn;
        end
    end

    // Configuration in use changes only between frames,
    // so a slot is never cut short by a mode change
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            act_r <= '{RST_MODE, RST_HALF_BIAS, RST_DISPLAY_ON};
        end else if (frameStart) begin
            act_r <= cfg_r;
        end
    end

    // Display memory copied at frame start, held for the whole frame
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            hold_r <= '0;
        end else if (frameStart) begin
            hold_r <= ramData;
        end
    end

    // Voltage selector: level per backplane and segment
    always_comb begin
        logic [4:0] pos;
        logic secondHalf;
        logic [1:0] slot;
        logic [1:0] den;
        logic [1:0] lv;
        logic isStatic;
        pos = frameCnt_r;
        secondHalf = 1'b0;
        slot = 2'h0;
        den = DEN_THIRD;
        lv = 2'h0;
        isStatic = (act_r.mode == MODE_STATIC);
        drive_nxt = '0;
        // Polarity flips each half frame to keep DC off the panel
        if (frameCnt_r >= HALF_LEN) begin
            pos = frameCnt_r - HALF_LEN;
            secondHalf = 1'b1;
        end
        slot = slotOf(pos, act_r.mode);
        // Denominator is one plus a, or one in static mode
        if (isStatic) begin
            den = DEN_STATIC;
        end else if (act_r.halfBias) begin
            den = DEN_HALF;
        end else begin
            den = DEN_THIRD;
        end
        drive_nxt.biasDenom = den;
        // Backplanes: selected at full level, others at the first step
        for (int b = 0; b < BP_N; b++) begin
            lv = (rowOf(2'(b), act_r.mode) == slot) ? den : 2'h1;
            if (secondHalf) begin
                lv = den - lv;
            end
            if (!act_r.displayOn) begin
                lv = den;
            end
            drive_nxt.backplane_outputs[b] = lv;
        end
        // Segments: on opposes the backplane, off sits near it
        for (int s = 0; s < SEG_N; s++) begin
            if (hold_r[s][slot]) begin
                lv = 2'h0;
            end else begin
                lv = isStatic ? den : den - 2'h1;
            end
            if (secondHalf) begin
                lv = den - lv;
            end
            if (!act_r.displayOn) begin
                lv = den;
            end
            drive_nxt.segment_outputs[s] = lv;
        end
    end

    // Drive levels registered so the pins never glitch
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            drive_r.biasDenom <= DEN_THIRD;
            drive_r.backplane_outputs <= {BP_N{DEN_THIRD}};
            drive_r.segment_outputs <= {SEG_N{DEN_THIRD}};
        end else if (clkEn) begin
            drive_r <= drive_nxt;
        end
    end

    // Divider never leaves its 24-tick range
    property p_frameWrap;
        @(posedge clock) disable iff (!nrst)
        tick && !syncRestart && frameCnt_r == FRAME_DIV - 5'h01 |=> frameCnt_r == 5'h00 && hold_r == $past(ramData);
    endproperty
    a_frameWrap: assert property (p_frameWrap) else $error("frame divider did not wrap at 24");

    // Sync from another device restarts the divider
    property p_syncAlign;
        @(posedge clock) disable iff (!nrst)
        tick && !syncPinIn_n && !syncPinOe |=> frameCnt_r == 5'h01;
    endproperty
    a_syncAlign: assert property (p_syncAlign) else $error("divider ignored cascade sync");

    // Internal mode drives the clock pin
    property p_clkDriven;
        @(posedge clock) disable iff (!nrst)
        strapTaken_r && !strap_r |-> clkPinOe && clkPinOut == oscLevel_r;
    endproperty
    a_clkDriven: assert property (p_clkDriven) else $error("internal clock not driven out");

    // External mode leaves the clock pin to the outside
    property p_clkInput;
        @(posedge clock) disable iff (!nrst)
        strap_r |-> !clkPinOe;
    endproperty
    a_clkInput: assert property (p_clkInput) else $error("clock pin driven in external mode");

    // Holding register changes only at a frame start
    property p_holdStable;
        @(posedge clock) disable iff (!nrst)
        !frameStart |=> $stable(hold_r);
    endproperty
    a_holdStable: assert property (p_holdStable) else $error("display data changed mid-frame");

    // Three-backplane mode copies backplane 1 onto 3
    property p_dupMux3;
        @(posedge clock) disable iff (!nrst)
        clkEn && act_r.mode == MODE_MUX3 |=>
            drive_r.backplane_outputs[3] == drive_r.backplane_outputs[1];
    endproperty
    a_dupMux3: assert property (p_dupMux3) else $error("backplane 3 differs from 1");

    // Two-backplane mode pairs 0 with 2 and 1 with 3
    property p_dupMux2;
        @(posedge clock) disable iff (!nrst)
        clkEn && act_r.mode == MODE_MUX2 |=>
            drive_r.backplane_outputs[2] == drive_r.backplane_outputs[0] &&
            drive_r.backplane_outputs[3] == drive_r.backplane_outputs[1];
    endproperty
    a_dupMux2: assert property (p_dupMux2) else $error("duplex backplanes not paired");

    // Half bias gives denominator two when multiplexed
    property p_biasDen;
        @(posedge clock) disable iff (!nrst)
        clkEn && act_r.mode != MODE_STATIC && act_r.halfBias |=> drive_r.biasDenom == 2'h2;
    endproperty
    a_biasDen: assert property (p_biasDen) else $error("half bias denominator wrong");

    // Disabled display holds every pin at the panel supply level
    property p_blankOff;
        @(posedge clock) disable iff (!nrst)
        clkEn && !act_r.displayOn |=>
            drive_r.backplane_outputs[0] == drive_r.biasDenom &&
            drive_r.segment_outputs[59] == drive_r.biasDenom;
    endproperty
    a_blankOff: assert property (p_blankOff) else $error("disabled display not at supply");
endmodule

// >>> testbench/lcdm_panel.sv
// Passive panel model that flags drive levels outside the selected bias range
`timescale 1ns/1ps
module lcdm_panel (
    // Clock and reset
    input wire logic clock,
    input wire logic nrst,
    // Drive levels from the device
    input wire lcdm_pkg::lcdm_drive_t drive,
    // Sticky flag, level above full scale seen
    output logic overRange
);
    import lcdm_pkg::*;

    // A level above the denominator would mean more than the panel supply
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            overRange <= 1'b0;
        end else begin
            for (int b = 0; b < BP_N; b++) begin
                if (drive.backplane_outputs[b] > drive.biasDenom) overRange <= 1'b1;
            end
            for (int s = 0; s < SEG_N; s++) begin
                if (drive.segment_outputs[s] > drive.biasDenom) overRange <= 1'b1;
            end
        end
    end
endmodule

// >>> testbench/lcdm_drive_timing_tb_top.sv
// Self-checking bench for the LCD drive timing block
`timescale 1ns/1ps
module lcdm_drive_timing_tb_top;
    import lcdm_pkg::*;
    logic clock = 1'b0;
    logic nrst = 1'b0;
    logic clkEn = 1'b1;
    logic intOscSel = 1'b0;
    logic clkPinIn = 1'b0;
    logic clkPinOut, clkPinOe, syncPinOut_n, syncPinOe, frameStart, overRange;
    logic benchSyncLow = 1'b0; // Bench's own pull on the sync wire
    logic extRun = 1'b0; // External clock generator running
    logic cfgWrite = 1'b0;
    lcdm_cfg_t cfgIn = '0;
    logic [SEG_N-1:0][3:0] ramData = '0;
    lcdm_drive_t drive;
    wire logic syncPinIn_n = ~(syncPinOe | benchSyncLow); // Wired-AND, pulled high
    int n_errors = 0;
    int compares = 0;
    int cycles = 0;
    int extCnt = 0;

    lcdm_drive_timing #(.oscHalfCycles(4)) dut (.clock(clock), .nrst(nrst), .clkEn(clkEn),
        .intOscSel(intOscSel), .clkPinIn(clkPinIn), .clkPinOut(clkPinOut), .clkPinOe(clkPinOe),
        .syncPinIn_n(syncPinIn_n), .syncPinOut_n(syncPinOut_n), .syncPinOe(syncPinOe),
        .cfgWrite(cfgWrite), .cfgIn(cfgIn), .ramData(ramData), .drive_r(drive), .frameStart(frameStart));
    lcdm_panel panel (.clock(clock), .nrst(nrst), .drive(drive), .overRange(overRange));

    // 50 MHz system clock
    always #10 clock = ~clock;
    // External working clock, never stopped once started; rising every 10 cycles
    always @(posedge clock) begin
        if (extRun) begin
            extCnt <= (extCnt == 4) ? 0 : extCnt + 1;
            if (extCnt == 4) clkPinIn <= ~clkPinIn;
        end
    end
    // Hang guard, well above the few thousand cycles the tests need
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_errors++;
            report_and_stop();
        end
    end

    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD %s expected %0h seen %0h", name, exp, seen);
        end
    endtask
    // Wait for a frame start at a settled point, counting cycles
    task automatic wait_frame(output int n);
        n = 0;
        do begin
            @(negedge clock);
            n++;
        end while (frameStart !== 1'b1 && n < 400);
    endtask
    task automatic write_cfg(input lcdm_cfg_t c);
        @(posedge clock);
        cfgIn <= c;
        cfgWrite <= 1'b1;
        @(posedge clock);
        cfgWrite <= 1'b0;
    endtask
    task automatic set_ram(input logic inv);
        @(posedge clock);
        for (int i = 0; i < SEG_N; i++) ramData[i] <= (i[0] ^ inv) ? 4'hA : 4'h5;
    endtask

    // Reset values while reset is held
    task automatic t_reset();
        @(negedge clock);
        check("biasDenom", drive.biasDenom, 8'h03);
        check("bp0", drive.backplane_outputs[0], 8'h03);
        check("seg59", drive.segment_outputs[59], 8'h03);
        check("clkPinOe", clkPinOe, 8'h00);
        check("syncPinOe", syncPinOe, 8'h01);
        $display("test reset done");
    endtask
    // Internal oscillator driven out, frame is 24 working ticks of 8 cycles
    task automatic t_internal();
        int n;
        logic lvl;
        wait_frame(n);
        wait_frame(n);
        check("clkPinOe", clkPinOe, 8'h01);
        check("framePeriod", n[7:0], 8'hC0);
        repeat (2) @(negedge clock);
        check("syncPinOe", syncPinOe, 8'h01);
        check("syncPinOut_n", syncPinOut_n, 8'h00);
        // Pin level inverts every four system cycles with the bench's divider
        lvl = clkPinOut;
        repeat (4) @(negedge clock);
        check("clkPinOut", clkPinOut, {7'h00, ~lvl});
        $display("test internal done");
    endtask
    // Enable low freezes divider and oscillator, so the frame stretches by exactly that long
    task automatic t_freeze();
        int n;
        wait_frame(n);
        @(posedge clock);
        clkEn <= 1'b0;
        repeat (50) @(posedge clock);
        clkEn <= 1'b1;
        wait_frame(n);
        check("freezePeriod", n[7:0], 8'hC0);
        $display("test freeze done");
    endtask
    // One drive configuration: levels in both halves and holding of data
    task automatic t_cfg(input lcdm_mode_t m, input logic half);
        int n;
        logic [1:0] den;
        den = (m == MODE_STATIC) ? 2'h1 : (half ? 2'h2 : 2'h3);
        set_ram(1'b0);
        wait_frame(n);
        write_cfg('{mode: m, halfBias: half, displayOn: 1'b1});
        wait_frame(n);
        repeat (2) @(negedge clock);
        check("biasDenom", drive.biasDenom, den);
        check("bp0", drive.backplane_outputs[0], den);
        check("bp2", drive.backplane_outputs[2], (m <= MODE_MUX2) ? den : 2'h1);
        check("bp3", drive.backplane_outputs[3], (m == MODE_STATIC) ? den : 2'h1);
        check("seg0", drive.segment_outputs[0], 8'h00);
        check("seg59", drive.segment_outputs[59], (m == MODE_STATIC) ? den : den - 2'h1);
        set_ram(1'b1);
        repeat (20) @(negedge clock);
        check("seg0held", drive.segment_outputs[0], 8'h00);
        repeat (82) @(negedge clock);
        check("bp0half1", drive.backplane_outputs[0], 8'h00);
        check("seg0half1", drive.segment_outputs[0], den);
        wait_frame(n);
        repeat (2) @(negedge clock);
        check("seg0new", drive.segment_outputs[0], (m == MODE_STATIC) ? den : den - 2'h1);
        $display("test cfg %0d %0d done", m, half);
    endtask
    // Back-to-back writes, last one wins; then display off
    task automatic t_last_and_off();
        int n;
        wait_frame(n);
        write_cfg('{mode: MODE_MUX2, halfBias: 1'b1, displayOn: 1'b1});
        write_cfg('{mode: MODE_MUX3, halfBias: 1'b0, displayOn: 1'b1});
        wait_frame(n);
        repeat (2) @(negedge clock);
        check("lastBias", drive.biasDenom, 8'h03);
        check("lastBp3", drive.backplane_outputs[3], 8'h01);
        write_cfg('{mode: MODE_MUX4, halfBias: 1'b0, displayOn: 1'b0});
        wait_frame(n);
        repeat (2) @(negedge clock);
        check("offBp1", drive.backplane_outputs[1], 8'h03);
        check("offSeg0", drive.segment_outputs[0], 8'h03);
        $display("test last and off done");
    endtask
    // Another device pulls sync mid-frame; this one restarts and aligns
    task automatic t_sync();
        int n;
        wait_frame(n);
        repeat (50) @(negedge clock);
        @(posedge clock);
        benchSyncLow <= 1'b1;
        n = 0;
        do begin
            @(negedge clock);
            n++;
        end while (frameStart !== 1'b1 && n < 12);
        check("syncRestart", frameStart, 8'h01);
        @(posedge clock);
        benchSyncLow <= 1'b0;
        wait_frame(n);
        check("syncPeriod", n[7:0], 8'hB8);
        $display("test sync done");
    endtask
    // Strap high: clock pin is an input, frame is 24 external edges
    task automatic t_external();
        int n;
        @(posedge clock);
        nrst <= 1'b0;
        intOscSel <= 1'b1;
        extRun <= 1'b1;
        repeat (3) @(posedge clock);
        nrst <= 1'b1;
        wait_frame(n);
        wait_frame(n);
        check("extOe", clkPinOe, 8'h00);
        check("extPeriod", n[7:0], 8'hF0);
        $display("test external done");
    endtask

    task automatic report_and_stop();
        $display("compares %0d n_errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        t_reset();
        repeat (2) @(posedge clock);
        nrst <= 1'b1;
        t_internal();
        t_freeze();
        for (int m = 0; m < 4; m++) begin
            t_cfg(lcdm_mode_t'(m), 1'b0);
            t_cfg(lcdm_mode_t'(m), 1'b1);
        end
        t_last_and_off();
        t_sync();
        t_external();
        check("overRange", overRange, 8'h00);
        report_and_stop();
    end
endmodule
